// [design/cvs_pkg.sv]
// Purpose: Constants, types and helpers for the core voltage sequencer.
// Assumes: 100 MHz hclk; sensed output level arrives as a word in 0.5 mV units.
// Notes: Voltages are held in 0.5 mV units so the 12.5 mV code step is whole.
package cvs_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned DEGLITCH_NS = 400;
    localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned BOOT_HOLD_US = 90;
    localparam int unsigned BOOT_HOLD_CYC = BOOT_HOLD_US * CLK_MHZ;
    localparam int unsigned PG_DELAY_MS = 9;
    localparam int unsigned PG_DELAY_CYC = PG_DELAY_MS * 1000 * CLK_MHZ;
    localparam int unsigned MASK_US = 130;
    localparam int unsigned MASK_CYC = MASK_US * CLK_MHZ;
    localparam int unsigned SS_STEP_NS = 1000;
    localparam int unsigned SS_STEP_CYC = (SS_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned TMR_W = 20;
    localparam int unsigned DG_W = 6;
    localparam int unsigned CODE_W = 7;
    localparam int unsigned VOLT_W = 12;
    localparam logic [VOLT_W-1:0] DAC_TOP_HMV = 12'hBB8;
    localparam logic [VOLT_W-1:0] DAC_STEP_HMV = 12'h019;
    localparam logic [VOLT_W:0] PG_BELOW_HMV = 13'h0258;
    localparam logic [VOLT_W:0] PG_ABOVE_HMV = 13'h0190;
    localparam logic [VOLT_W:0] DROOP_EXT_HMV = 13'h0190;
    localparam logic [CODE_W-1:0] CODE_LOWEST = 7'h7F;
    localparam logic [CODE_W-1:0] BOOT_CODE_RST = 7'h20;
    localparam logic [1:0] PHASE_CFG_RST = 2'h3;
    localparam logic [1:0] PHASE_ONE = 2'h1;
    localparam logic [1:0] PHASE_TWO = 2'h2;
    localparam logic [31:0] REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS = 32'h0000_0004;
    localparam logic [31:0] REG_CODE = 32'h0000_0008;
    localparam int unsigned CTRL_BOOT_LSB = 0;
    localparam int unsigned CTRL_PH_LSB = 8;
    localparam int unsigned CODE_TGT_LSB = 8;

    typedef enum logic [4:0] {
        ST_OFF  = 5'h01,
        ST_SS   = 5'h02,
        ST_BOOT = 5'h04,
        ST_PGD  = 5'h08,
        ST_RUN  = 5'h10
    } cvs_state_e;

    typedef struct packed {
        logic [4:0] state;
        logic pwm_enable;
        logic [1:0] phases;
        logic pwm_mode;
        logic masked;
        logic cpu_clock_enable_n_n;
        logic power_good;
    } cvs_status_s;

    // DAC setpoint in 0.5 mV units; codes past the bottom clamp to zero
    function automatic logic [VOLT_W-1:0] code_to_hmv(input logic [CODE_W-1:0] code);
        logic [VOLT_W-1:0] drop;
        drop = VOLT_W'({5'h00, code} * DAC_STEP_HMV);
        code_to_hmv = (drop >= DAC_TOP_HMV) ? 12'h000 : DAC_TOP_HMV - drop;
    endfunction
endpackage

// [design/cvs_sequencer.sv]
// Purpose: Startup sequencing, code deglitch, power-good masking and phase/mode selection.
// Assumes: AHB-Lite slave, zero wait states; output_sense_reference is on the hclk domain.
// Notes: Pin inputs pass a two-flop synchroniser before any logic reads them.
`timescale 1ns/1ps
module cvs_sequencer
    import cvs_pkg::*;
#(
    parameter int unsigned P_BOOT_HOLD_CYC = BOOT_HOLD_CYC,
    parameter int unsigned P_PG_DELAY_CYC = PG_DELAY_CYC,
    parameter int unsigned P_MASK_CYC = MASK_CYC
) (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Always ready
    output logic hresp, // Always OKAY
    input wire logic enable, // Converter enable pin
    input wire logic supply_ok, // High when supply above lockout
    input wire logic [6:0] voltage_code, // Processor voltage code pins
    input wire logic deep_sleep_request, // Deeper sleep pin
    input wire logic low_load_indicator_n, // Low when load is light
    input wire logic overload_trip, // Current limit comparator
    input wire logic latchoff_done, // Delayed latchoff cycle ended
    input wire logic [11:0] output_sense_reference, // Sensed output, 0.5 mV units
    output logic [6:0] dac_code, // DAC setpoint code
    output logic power_good_out, // Power good level
    output logic power_good_oe, // Open-drain pull-down enable
    output logic cpu_clock_enable_n, // CPU clock enable, active low
    output logic pwm_enable, // Low holds all PWM outputs low
    output logic pwm_mode, // 1 PWM, 0 ripple-regulated
    output logic [1:0] phase_count // Phases in operation
);
    localparam int unsigned SYNC_W = 13;
    logic [SYNC_W-1:0] sync1_reg, sync2_reg;
    logic en_ok, dsl_s, psi_n_s, ovl_s, lod_s;
    logic [CODE_W-1:0] code_s;
    cvs_state_e state_reg;
    logic [TMR_W-1:0] tmr_reg, mask_reg, pgd_cnt_reg;
    logic [CODE_W-1:0] boot_code_reg, cand_reg;
    logic [1:0] phase_cfg_reg;
    logic [DG_W-1:0] dg_reg;
    logic dsl_d_reg, sleep_mask_reg, ovl_hold_reg, masked, vid_accept, sleep_edge;
    logic [VOLT_W:0] dac_hmv, sense_hmv;
    logic in_window, droop_big, heavy;
    logic addr_ph_reg, wr_ph_reg;
    logic [31:0] addr_reg;
    cvs_status_s status;

    // Two-flop synchroniser for all pin inputs; code skew is filtered later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {latchoff_done, overload_trip, low_load_indicator_n, deep_sleep_request,
                          supply_ok, enable, voltage_code};
            sync2_reg <= sync1_reg;
        end
    end
    assign code_s = sync2_reg[6:0];
    assign en_ok = sync2_reg[7] & sync2_reg[8];
    assign dsl_s = sync2_reg[9];
    assign psi_n_s = sync2_reg[10];
    assign ovl_s = sync2_reg[11];
    assign lod_s = sync2_reg[12];

    // Startup sequence: soft-start, boot hold, power-good delay, run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_OFF;
            tmr_reg <= '0;
            dac_code <= CODE_LOWEST;
            cpu_clock_enable_n <= 1'b1;
        end else if (!en_ok) begin
            state_reg <= ST_OFF;
            tmr_reg <= '0;
            dac_code <= CODE_LOWEST;
            cpu_clock_enable_n <= 1'b1;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    state_reg <= ST_SS;
                    tmr_reg <= '0;
                end
                ST_SS: begin
                    // Boot hold starts as soon as the boot code is reached, not one step later
                    if (dac_code == boot_code_reg) begin
                        tmr_reg <= '0;
                        state_reg <= ST_BOOT;
                    end else if (tmr_reg == TMR_W'(SS_STEP_CYC - 1)) begin
                        tmr_reg <= '0;
                        if (dac_code > boot_code_reg) begin
                            dac_code <= dac_code - 7'h01;
                        end else begin
                            dac_code <= dac_code + 7'h01;
                        end
                    end else begin
                        tmr_reg <= tmr_reg + 1'b1;
                    end
                end
                ST_BOOT: begin
                    if (tmr_reg == TMR_W'(P_BOOT_HOLD_CYC - 1)) begin
                        tmr_reg <= '0;
                        state_reg <= ST_PGD;
                        cpu_clock_enable_n <= 1'b0;
                    end else begin
                        tmr_reg <= tmr_reg + 1'b1;
                    end
                end
                ST_PGD: begin
                    if (vid_accept) begin
                        dac_code <= cand_reg;
                    end
                    if (tmr_reg == TMR_W'(P_PG_DELAY_CYC - 1)) begin
                        tmr_reg <= '0;
                        state_reg <= ST_RUN;
                    end else begin
                        tmr_reg <= tmr_reg + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (vid_accept) begin
                        dac_code <= cand_reg;
                    end
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // Code deglitch; the processor walks the code one step at a time, so each step is one acceptance
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cand_reg <= CODE_LOWEST;
            dg_reg <= '0;
        end else if (cpu_clock_enable_n || code_s != cand_reg) begin
            cand_reg <= code_s;
            dg_reg <= '0;
        end else if (dg_reg != DG_W'(DEGLITCH_CYC - 1)) begin
            dg_reg <= dg_reg + 1'b1;
        end
    end
    assign vid_accept = !cpu_clock_enable_n && code_s == cand_reg && cand_reg != dac_code &&
                        dg_reg == DG_W'(DEGLITCH_CYC - 1);

    // Window comparator in 0.5 mV units with one extra bit for headroom
    assign dac_hmv = {1'b0, code_to_hmv(dac_code)};
    assign sense_hmv = {1'b0, output_sense_reference};
    assign in_window = (sense_hmv <= dac_hmv + PG_ABOVE_HMV) &&
                       (dac_hmv < PG_BELOW_HMV || sense_hmv + PG_BELOW_HMV >= dac_hmv);
    assign droop_big = dac_hmv > sense_hmv + DROOP_EXT_HMV;

    // Power-good mask timer; retriggers on every accepted code and on sleep edges
    assign sleep_edge = dsl_s != dsl_d_reg;
    assign masked = mask_reg != '0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dsl_d_reg <= 1'b0;
            mask_reg <= '0;
            sleep_mask_reg <= 1'b0;
        end else begin
            dsl_d_reg <= dsl_s;
            if (vid_accept || sleep_edge) begin
                mask_reg <= TMR_W'(P_MASK_CYC);
            end else if (sleep_mask_reg && masked && droop_big) begin
                mask_reg <= mask_reg;
            end else if (masked) begin
                mask_reg <= mask_reg - 1'b1;
            end
            // Extension applies only to masks begun by a sleep edge
            if (sleep_edge) begin
                sleep_mask_reg <= 1'b1;
            end else if (vid_accept || !masked) begin
                sleep_mask_reg <= 1'b0;
            end
        end
    end

    // Power good: low until the delay ends, held while masked, else the window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_good_out <= 1'b0;
        end else if (!en_ok || state_reg != ST_RUN) begin
            power_good_out <= en_ok && state_reg == ST_PGD && tmr_reg == TMR_W'(P_PG_DELAY_CYC - 1);
        end else if (!masked) begin
            power_good_out <= in_window;
        end
    end
    assign power_good_oe = !power_good_out;

    // Overload keeps the configured phases in PWM until latchoff ends, but one PWM phase in deep sleep; the set wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovl_hold_reg <= 1'b0;
        end else if (ovl_s) begin
            ovl_hold_reg <= 1'b1;
        end else if (lod_s || !en_ok) begin
            ovl_hold_reg <= 1'b0;
        end
    end

    // Phase count and control mode
    assign heavy = psi_n_s && !dsl_s;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_enable <= 1'b0;
            pwm_mode <= 1'b1;
            phase_count <= PHASE_ONE;
        end else begin
            pwm_enable <= en_ok && state_reg != ST_OFF;
            if (masked) begin
                pwm_mode <= 1'b1;
                phase_count <= (phase_cfg_reg == PHASE_ONE) ? PHASE_TWO : phase_cfg_reg;
            end else if (heavy || (ovl_hold_reg && !dsl_s)) begin
                pwm_mode <= 1'b1;
                phase_count <= phase_cfg_reg;
            end else begin
                pwm_mode <= ovl_hold_reg;
                phase_count <= PHASE_ONE;
            end
        end
    end

    // AHB-Lite slave: never stalls, always OKAY, read data registered at address phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign status = '{state: state_reg, pwm_enable: pwm_enable, phases: phase_count, pwm_mode: pwm_mode,
                      masked: masked, cpu_clock_enable_n_n: cpu_clock_enable_n, power_good: power_good_out};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ph_reg <= 1'b0;
            wr_ph_reg <= 1'b0;
            addr_reg <= '0;
            hrdata <= '0;
        end else begin
            addr_ph_reg <= hsel && hready && htrans[1];
            wr_ph_reg <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                addr_reg <= haddr;
                if (hwrite) begin
                    hrdata <= '0;
                end else if (haddr == REG_CTRL) begin
                    hrdata <= 32'({phase_cfg_reg, 1'b0, boot_code_reg});
                end else if (haddr == REG_STATUS) begin
                    hrdata <= 32'(status);
                end else if (haddr == REG_CODE) begin
                    hrdata <= 32'({cand_reg, 1'b0, dac_code});
                end else begin
                    hrdata <= '0;
                end
            end
        end
    end

    // Control register write in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boot_code_reg <= BOOT_CODE_RST;
            phase_cfg_reg <= PHASE_CFG_RST;
        end else if (wr_ph_reg && addr_ph_reg && addr_reg == REG_CTRL) begin
            boot_code_reg <= hwdata[CTRL_BOOT_LSB +: CODE_W];
            phase_cfg_reg <= (hwdata[CTRL_PH_LSB +: 2] == 2'h0) ? PHASE_ONE : hwdata[CTRL_PH_LSB +: 2];
        end
    end

    // Helper: cycles spent in the power-good delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pgd_cnt_reg <= '0;
        end else if (cpu_clock_enable_n) begin
            pgd_cnt_reg <= '0;
        end else if (state_reg == ST_PGD) begin
            pgd_cnt_reg <= pgd_cnt_reg + 1'b1;
        end
    end

    sequence s_masked_run;
        masked [*8];
    endsequence
    sequence s_no_accept;
        !vid_accept [*8];
    endsequence
    property p_off;
        @(posedge hclk) disable iff (!hresetn) !en_ok |=> state_reg == ST_OFF ##1 !pwm_enable && !power_good_out;
    endproperty
    a_off: assert property (p_off) else $error("not shut down when disabled");
    property p_ss_step;
        @(posedge hclk) disable iff (!hresetn)
            state_reg == ST_SS && $past(state_reg == ST_SS) && $changed(dac_code) |->
            (dac_code == $past(dac_code) - 7'h01 || dac_code == $past(dac_code) + 7'h01);
    endproperty
    a_ss_step: assert property (p_ss_step) else $error("soft-start skipped a code");
    property p_cpu_clock_enable_n;
        @(posedge hclk) disable iff (!hresetn) $fell(cpu_clock_enable_n) |-> $past(state_reg == ST_BOOT);
    endproperty
    a_cpu_clock_enable_n: assert property (p_cpu_clock_enable_n) else $error("clock enable without boot hold");
    property p_pg_delay;
        @(posedge hclk) disable iff (!hresetn)
            $rose(power_good_out) && $past(state_reg == ST_PGD) |-> pgd_cnt_reg == TMR_W'(P_PG_DELAY_CYC);
    endproperty
    a_pg_delay: assert property (p_pg_delay) else $error("power good delay wrong");
    property p_ignore;
        @(posedge hclk) disable iff (!hresetn)
            cpu_clock_enable_n && state_reg != ST_SS |-> !vid_accept ##1 ($stable(dac_code) || !$past(en_ok));
    endproperty
    a_ignore: assert property (p_ignore) else $error("code used before clock enable");
    property p_holdoff;
        @(posedge hclk) disable iff (!hresetn) $changed(code_s) |=> s_no_accept;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("code taken too early");
    property p_mask;
        @(posedge hclk) disable iff (!hresetn) vid_accept |=> s_masked_run;
    endproperty
    a_mask: assert property (p_mask) else $error("mask not started on code change");
    property p_pwm_forced;
        @(posedge hclk) disable iff (!hresetn) masked |=> pwm_mode && phase_count != PHASE_ONE;
    endproperty
    a_pwm_forced: assert property (p_pwm_forced) else $error("transient not in multi-phase PWM");
    property p_follow;
        @(posedge hclk) disable iff (!hresetn)
            en_ok && state_reg == ST_RUN && !masked |=> power_good_out == $past(in_window) || !$past(en_ok);
    endproperty
    a_follow: assert property (p_follow) else $error("power good not following window");
    property p_low_dac;
        @(posedge hclk) disable iff (!hresetn)
            en_ok && state_reg == ST_RUN && !masked && dac_hmv < PG_BELOW_HMV &&
            sense_hmv <= dac_hmv + PG_ABOVE_HMV |=> power_good_out;
    endproperty
    a_low_dac: assert property (p_low_dac) else $error("lower bound used at low setpoint");
endmodule // cvs_sequencer

// [testbench/cvs_cpu_model.sv]
// Purpose: Processor side of the voltage code pins.
// Assumes: The processor moves its code only while its clock runs.
// Notes: Each step shows a two-cycle inter-bit skew value before the final code.
`timescale 1ns/1ps
module cvs_cpu_model #(
    parameter int GAP = 50
) (
    input wire logic hclk, // Bench clock
    input wire logic cpu_clock_enable_n, // Processor clock gate, active low
    input wire logic [6:0] target, // Code to move towards
    output logic [6:0] voltage_code // Code pins
);
    int cnt = 0;
    logic [6:0] nxt = 7'h20;
    initial voltage_code = 7'h20;
    // One LSB per step; skew shows old OR new so the deglitch must wait it out
    always @(posedge hclk) begin
        cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
        if (cnt == 0 && !cpu_clock_enable_n && voltage_code != target) begin
            nxt <= (target > voltage_code) ? voltage_code + 7'h01 : voltage_code - 7'h01;
            voltage_code <= voltage_code | ((target > voltage_code) ? voltage_code + 7'h01 : voltage_code - 7'h01);
        end
        if (cnt == 2) begin
            voltage_code <= nxt;
        end
    end
endmodule // cvs_cpu_model

// [testbench/test_core_voltage_sequencer.sv]
// Purpose: Self-checking bench for the core voltage sequencer.
// Assumes: Shortened boot, power-good delay and mask counts.
// Notes: Sensed output tracks the DAC level plus a bench offset in 0.5 mV units.
`timescale 1ns/1ps
module test_core_voltage_sequencer;
    import cvs_pkg::*;
    localparam int BOOT = 50;
    localparam int PGD = 200;
    localparam int MASK = 60;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, phase_count;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, power_good_out, power_good_oe, cpu_clock_enable_n, pwm_enable, pwm_mode;
    logic enable = 1'b0, supply_ok = 1'b0, deep_sleep_request = 1'b0, low_load_indicator_n = 1'b1;
    logic overload_trip = 1'b0, latchoff_done = 1'b0;
    logic [6:0] voltage_code, dac_code, target = 7'h20, prev;
    logic [11:0] output_sense_reference;
    int sense_off = 0, error_cnt = 0, n_compared = 0, n;
    int offs [5] = '{400, 401, -600, -601, 0};
    logic exp_pg [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    function automatic int hmv(input logic [6:0] c);
        int d;
        d = int'(c) * int'(DAC_STEP_HMV);
        hmv = (d >= int'(DAC_TOP_HMV)) ? 0 : int'(DAC_TOP_HMV) - d;
    endfunction
    // Analog stand-in: output settles on the commanded level plus offset
    assign output_sense_reference = 12'(hmv(dac_code) + sense_off);

    cvs_sequencer #(.P_BOOT_HOLD_CYC(BOOT), .P_PG_DELAY_CYC(PGD), .P_MASK_CYC(MASK)) i_cvs_sequencer (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .enable(enable), .supply_ok(supply_ok), .voltage_code(voltage_code),
        .deep_sleep_request(deep_sleep_request), .low_load_indicator_n(low_load_indicator_n),
        .overload_trip(overload_trip), .latchoff_done(latchoff_done),
        .output_sense_reference(output_sense_reference), .dac_code(dac_code),
        .power_good_out(power_good_out), .power_good_oe(power_good_oe),
        .cpu_clock_enable_n(cpu_clock_enable_n), .pwm_enable(pwm_enable), .pwm_mode(pwm_mode),
        .phase_count(phase_count));
    cvs_cpu_model #(.GAP(50)) i_cvs_cpu_model (.hclk(hclk), .cpu_clock_enable_n(cpu_clock_enable_n),
        .target(target), .voltage_code(voltage_code));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single word transfer; waits on ready, never on a fixed count
    task automatic ahb_xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial forever #5 hclk = ~hclk;
    // Watchdog well past the expected run of about 13500 cycles
    initial begin
        repeat (40000) @(posedge hclk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(negedge hclk);
        chk({dac_code, power_good_out, power_good_oe, cpu_clock_enable_n, pwm_enable}, 11'h7F6);
        @(posedge hclk);
        hresetn <= 1'b1;
        ahb_xfer(REG_CTRL, 1'b0, 32'h0, rd);
        chk(rd, 32'h0000_0320);
        ahb_xfer(32'h0000_0010, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test reset done");
        // Soft-start: one code step at a time, pins ignored until clock enable
        @(posedge hclk);
        enable <= 1'b1;
        supply_ok <= 1'b1;
        prev = 7'h7F;
        for (n = 0; n < 12000 && dac_code !== 7'h20; n++) begin
            @(negedge hclk);
            if (dac_code !== prev) begin
                chk(dac_code, prev - 7'h01);
                prev = dac_code;
            end
        end
        for (n = 0; n < 1000 && cpu_clock_enable_n !== 1'b0; n++) @(negedge hclk);
        chk(n >= BOOT && n <= BOOT + 2, 1);
        chk({dac_code, power_good_out}, {7'h20, 1'b0});
        for (n = 0; n < 1000 && power_good_out !== 1'b1; n++) @(negedge hclk);
        chk(n >= PGD && n <= PGD + 2, 1);
        $display("test startup done");
        // Light load, then one step with a bad output held off by the mask
        @(posedge hclk);
        low_load_indicator_n <= 1'b0;
        repeat (4) @(negedge hclk);
        chk({phase_count, pwm_mode}, 3'b010);
        @(posedge hclk);
        target <= 7'h21;
        for (n = 0; n < 200 && voltage_code !== 7'h21; n++) @(negedge hclk);
        for (n = 0; n < 100 && dac_code !== 7'h21; n++) @(negedge hclk);
        chk(n >= DEGLITCH_CYC && n <= DEGLITCH_CYC + 6, 1);
        chk(dac_code, 7'h21);
        @(posedge hclk);
        sense_off <= 401;
        @(negedge hclk);
        chk({phase_count, pwm_mode, power_good_out}, 4'hF);
        for (n = 0; n < 200 && power_good_out !== 1'b0; n++) @(negedge hclk);
        chk(n >= MASK - 5 && n <= MASK + 2, 1);
        // Window edges: inside and one half millivolt outside each bound
        foreach (offs[i]) begin
            @(posedge hclk);
            sense_off <= offs[i];
            repeat (3) @(negedge hclk);
            chk(power_good_out, exp_pg[i]);
        end
        $display("test step and window done");
        // Long walk down with one phase configured; mask must never lapse
        ahb_xfer(REG_CTRL, 1'b1, 32'h0000_0120, rd);
        target <= 7'h61;
        prev = 7'h21;
        for (n = 0; n < 200 && dac_code === 7'h21; n++) @(negedge hclk);
        // Phase outputs follow the mask one edge later
        @(negedge hclk);
        for (n = 0; n < 5000 && dac_code !== 7'h61; n++) begin
            chk({phase_count, pwm_mode}, 3'b101);
            if (dac_code !== prev) begin
                chk(dac_code, prev + 7'h01);
                prev = dac_code;
            end
            @(negedge hclk);
        end
        @(posedge hclk);
        sense_off <= -575;
        repeat (MASK + 10) @(negedge hclk);
        chk({phase_count, pwm_mode, power_good_out}, 4'b0101);
        ahb_xfer(REG_CODE, 1'b0, 32'h0, rd);
        chk(rd[6:0], 7'h61);
        sense_off <= 401;
        repeat (3) @(negedge hclk);
        chk(power_good_out, 1'b0);
        $display("test walk down done");
        // Overload restores configured phases until latchoff ends
        ahb_xfer(REG_CTRL, 1'b1, 32'h0000_0320, rd);
        sense_off <= 0;
        overload_trip <= 1'b1;
        repeat (5) @(negedge hclk);
        chk({phase_count, pwm_mode}, 3'b111);
        @(posedge hclk);
        overload_trip <= 1'b0;
        repeat (4) @(negedge hclk);
        chk({phase_count, pwm_mode}, 3'b111);
        @(posedge hclk);
        latchoff_done <= 1'b1;
        repeat (5) @(negedge hclk);
        chk({phase_count, pwm_mode}, 3'b010);
        $display("test overload done");
        // Sleep entry masks; a deep droop on sleep exit stretches the mask
        @(posedge hclk);
        latchoff_done <= 1'b0;
        deep_sleep_request <= 1'b1;
        low_load_indicator_n <= 1'b1;
        // Sync plus edge detect before the mask is loaded
        repeat (4) @(negedge hclk);
        ahb_xfer(REG_STATUS, 1'b0, 32'h0, rd);
        chk(rd[2], 1'b1);
        repeat (MASK + 10) @(negedge hclk);
        chk({phase_count, pwm_mode}, 3'b010);
        @(posedge hclk);
        deep_sleep_request <= 1'b0;
        repeat (6) @(posedge hclk);
        sense_off <= -401;
        repeat (2 * MASK) @(negedge hclk);
        ahb_xfer(REG_STATUS, 1'b0, 32'h0, rd);
        chk(rd[2], 1'b1);
        sense_off <= 0;
        repeat (MASK + 10) @(negedge hclk);
        ahb_xfer(REG_STATUS, 1'b0, 32'h0, rd);
        chk({rd[2], phase_count, pwm_mode}, 4'b0111);
        $display("test sleep done");
        // Shutdown drops everything at once
        enable <= 1'b0;
        repeat (5) @(negedge hclk);
        chk({pwm_enable, cpu_clock_enable_n, power_good_out, power_good_oe}, 4'b0101);
        $display("test shutdown done");
        report_and_stop();
    end
endmodule // test_core_voltage_sequencer
